// file: rtl/supervisor_pkg.sv
// shared constants, types and timing for the supply, reset and watchdog supervisor
`default_nettype none
package supervisor_pkg;
    // clock and counter sizing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CNT_W = 24;

    // whole cycles for a time given in microseconds, rounded up
    function automatic int unsigned us_cyc(input int unsigned us);
        return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    // supervisory times in microseconds
    localparam int unsigned RESET_4_US = 4000;
    localparam int unsigned RESET_8_US = 8000;
    localparam int unsigned RESET_16_US = 16000;
    localparam int unsigned RESET_32_US = 32000;
    localparam int unsigned TMP_SD_US = 128000;
    localparam int unsigned WD_CLOSED_BASE_US = 10000;
    localparam int unsigned WD_SERVICE_BASE_US = 10000;
    localparam int unsigned TX_TIMEOUT_US = 6000;
    localparam int unsigned WAKE_US = 150;
    localparam int unsigned REG_RESTART_US = 1000;
    localparam int unsigned UV_GLITCH_US = 10;

    // the same times as clock cycles
    localparam int unsigned RESET_4_CYC = us_cyc(RESET_4_US);
    localparam int unsigned RESET_8_CYC = us_cyc(RESET_8_US);
    localparam int unsigned RESET_16_CYC = us_cyc(RESET_16_US);
    localparam int unsigned RESET_32_CYC = us_cyc(RESET_32_US);
    localparam int unsigned TMP_SD_CYC = us_cyc(TMP_SD_US);
    localparam int unsigned WD_CLOSED_BASE_CYC = us_cyc(WD_CLOSED_BASE_US);
    localparam int unsigned WD_SERVICE_BASE_CYC = us_cyc(WD_SERVICE_BASE_US);
    localparam int unsigned TX_TIMEOUT_CYC = us_cyc(TX_TIMEOUT_US);
    localparam int unsigned WAKE_CYC = us_cyc(WAKE_US);
    localparam int unsigned REG_RESTART_CYC = us_cyc(REG_RESTART_US);
    localparam logic [23:0] UV_GLITCH_CYC = 24'(us_cyc(UV_GLITCH_US));

    // register map (byte addresses)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFS = 12'h000;
    localparam logic [11:0] STATUS_OFFS = 12'h004;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // control register fields
    localparam int unsigned CTRL_WD_TRIG_BIT = 0;
    localparam int unsigned CTRL_ATTEN_BIT = 1;
    localparam int unsigned CTRL_TLIM_DIS_BIT = 2;
    localparam int unsigned CTRL_TMP_SD_BIT = 3;

    // status register fields
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_OT_WARN_BIT = 4;
    localparam int unsigned ST_RWAKE_BIT = 5;
    localparam int unsigned ST_TXTO_BIT = 6;
    localparam int unsigned ST_RESET_BIT = 7;
    localparam int unsigned ST_VCC_GOOD_BIT = 8;
    localparam int unsigned ST_WD_FAULT_BIT = 9;

    // operating modes
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_NORMAL = 3'h1,
        MODE_STANDBY = 3'h2,
        MODE_TMP_SD = 3'h3,
        MODE_THERMAL = 3'h4
    } mode_e;

    // window watchdog phases
    typedef enum logic [1:0] {
        WD_IDLE = 2'h0,
        WD_CLOSED = 2'h1,
        WD_SERVICE = 2'h2
    } wd_phase_e;

    // factory one-time programmable settings
    typedef struct packed {
        logic [1:0] reset_sel;
        logic [1:0] uv_thr_sel;
        logic wd_en;
        logic [1:0] wd_closed_sel;
        logic [1:0] wd_service_sel;
    } otp_cfg_s;
endpackage
`default_nettype wire

// file: rtl/supply_reset_watchdog_supervisor.sv
// supply sequencing, reset stretch, window watchdog and link guards of the power die
//
// Local design decisions: register access over APB and the register offsets.
`default_nettype none
module supply_reset_watchdog_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned RES_4_CYC = RESET_4_CYC,
    parameter int unsigned RES_8_CYC = RESET_8_CYC,
    parameter int unsigned RES_16_CYC = RESET_16_CYC,
    parameter int unsigned RES_32_CYC = RESET_32_CYC,
    parameter int unsigned TMP_CYC = TMP_SD_CYC,
    parameter int unsigned WDC_BASE_CYC = WD_CLOSED_BASE_CYC,
    parameter int unsigned WDS_BASE_CYC = WD_SERVICE_BASE_CYC,
    parameter int unsigned TXTO_CYC = TX_TIMEOUT_CYC,
    parameter int unsigned WAKE_T_CYC = WAKE_CYC,
    parameter int unsigned RESTART_CYC = REG_RESTART_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog indications and factory settings
    input wire logic battery_supply_good_n,
    input wire logic vcc_below_assert,
    input wire logic vcc_above_release,
    input wire logic temp_shutdown_ind,
    input wire logic temp_warning_ind,
    input wire logic temp_recovery_ind,
    input wire otp_cfg_s otp_cfg,
    // controller and bus pins
    input wire logic enable_in,
    input wire logic measurement_enable_input,
    input wire logic tx_in,
    input wire logic bus_wake_dominant,
    input wire logic reset_pin_in,
    // controls to the analog blocks and pins
    output logic regulator_en,
    output logic transceiver_en,
    output logic bus_tx_dominant,
    output logic atten_en,
    output logic [1:0] uv_threshold_sel,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic interrupt_pin_n
);
    logic [5:0] sync1_q; // first synchroniser stage, read only by the second
    logic [5:0] sync2_q; // synchronised indications
    logic batt_good, vcc_below, vcc_above, temp_sd, temp_warn, temp_rec;
    mode_e mode_q; // operating mode
    otp_cfg_s otp_q; // settings frozen while the device runs
    logic [31:0] ctrl_q; // control register
    logic wd_trig_q; // one-cycle trigger event
    logic vcc_good_q; // regulated-supply-good
    logic [CNT_W-1:0] glitch_cnt_q; // time spent below the assert threshold
    logic [CNT_W-1:0] restart_cnt_q; // regulator off time after vcc failure
    logic [CNT_W-1:0] stretch_cnt_q; // remaining reset stretch
    logic [CNT_W-1:0] tmp_cnt_q; // temporary shutdown timer
    wd_phase_e wd_phase_q; // watchdog phase
    logic [CNT_W-1:0] wd_cnt_q; // time within the watchdog phase
    logic wd_fault_q; // one-cycle watchdog failure
    logic wd_flag_q; // sticky watchdog failure flag
    logic [CNT_W-1:0] tx_cnt_q; // dominant transmit time
    logic tx_to_q; // transmit timeout latched until tx released
    logic [CNT_W-1:0] wake_cnt_q; // dominant bus time in standby
    logic rwake_q; // remote wake flag
    logic ot_warn_q; // over-temperature warning flag
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic reg_en_q, xcvr_q, bus_dom_q, atten_q, rst_oe_n_q, int_n_q, en_prev_q;
    logic vcc_fall, tsd_hit, wake_hit, reset_active, wd_run, setup, wr_acc;
    logic [CNT_W-1:0] closed_len, service_len;

    // decode of a register offset, shared by read and write paths
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction

    // window length: base doubled per setting step
    function automatic logic [CNT_W-1:0] wd_len(input logic [1:0] sel, input int unsigned base);
        return CNT_W'(base) << sel;
    endfunction

    // stretch length from the factory setting; unprogrammed gives the default
    function automatic logic [CNT_W-1:0] stretch_len(input logic [1:0] sel);
        case (sel)
            2'h1: return CNT_W'(RES_4_CYC);
            2'h2: return CNT_W'(RES_16_CYC);
            2'h3: return CNT_W'(RES_32_CYC);
            default: return CNT_W'(RES_8_CYC);
        endcase
    endfunction

    // analog indications are asynchronous; two flops before any use
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= {battery_supply_good_n, vcc_below_assert, vcc_above_release,
                        temp_shutdown_ind, temp_warning_ind, temp_recovery_ind};
            sync2_q <= sync1_q;
        end
    end

    assign batt_good = sync2_q[5];
    assign vcc_below = sync2_q[4];
    assign vcc_above = sync2_q[3];
    assign temp_sd = sync2_q[2];
    assign temp_warn = sync2_q[1];
    assign temp_rec = sync2_q[0];
    assign tsd_hit = temp_sd && !ctrl_q[CTRL_TLIM_DIS_BIT];
    assign wake_hit = (mode_q == MODE_STANDBY) && bus_wake_dominant
                      && (wake_cnt_q == CNT_W'(WAKE_T_CYC - 1));
    assign vcc_fall = vcc_good_q && !vcc_above && (glitch_cnt_q == UV_GLITCH_CYC - 24'h1);
    assign reset_active = !vcc_good_q || (stretch_cnt_q != 24'h0);
    assign wd_run = otp_q.wd_en && (mode_q == MODE_NORMAL) && !reset_active;
    assign closed_len = wd_len(otp_q.wd_closed_sel, WDC_BASE_CYC);
    assign service_len = wd_len(otp_q.wd_service_sel, WDS_BASE_CYC);
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pready_q && !pslverr_q;

    // mode sequencer; battery under-voltage outranks everything
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_OFF;
        end else if (!batt_good) begin
            mode_q <= MODE_OFF;
        end else begin
            case (mode_q)
                MODE_OFF: mode_q <= MODE_NORMAL;
                MODE_NORMAL: begin
                    if (tsd_hit) begin
                        mode_q <= MODE_THERMAL;
                    end else if (ctrl_q[CTRL_TMP_SD_BIT]) begin
                        mode_q <= MODE_TMP_SD;
                    end else if (!enable_in && en_prev_q) begin
                        mode_q <= MODE_STANDBY; // falling enable only, so a wake sticks
                    end
                end
                MODE_STANDBY: begin
                    if (tsd_hit) begin
                        mode_q <= MODE_THERMAL;
                    end else if (ctrl_q[CTRL_TMP_SD_BIT]) begin
                        mode_q <= MODE_TMP_SD;
                    end else if (wake_hit || enable_in) begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                MODE_TMP_SD: begin
                    if (tmp_cnt_q == 24'h0) begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                MODE_THERMAL: begin
                    if (temp_rec) begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                default: mode_q <= MODE_OFF;
            endcase
        end
    end

    // temporary shutdown timer, reloaded whenever the mode is left
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmp_cnt_q <= 24'h0;
        end else if (mode_q != MODE_TMP_SD) begin
            tmp_cnt_q <= CNT_W'(TMP_CYC - 1);
        end else if (tmp_cnt_q != 24'h0) begin
            tmp_cnt_q <= tmp_cnt_q - 24'h1;
        end
    end

    // factory settings follow the fuses only while powered off, then stay frozen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            otp_q <= '0;
        end else if (mode_q == MODE_OFF) begin
            otp_q <= otp_cfg;
        end
    end

    // regulated-supply-good with glitch rejection; a short dip never reaches reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vcc_good_q <= 1'b0;
            glitch_cnt_q <= 24'h0;
        end else if (mode_q == MODE_OFF) begin
            vcc_good_q <= 1'b0;
            glitch_cnt_q <= 24'h0;
        end else if (vcc_good_q) begin
            if (vcc_fall) begin
                vcc_good_q <= 1'b0;
                glitch_cnt_q <= 24'h0;
            end else if (vcc_above) begin
                glitch_cnt_q <= 24'h0;
            end else if (vcc_below || glitch_cnt_q != 24'h0) begin
                glitch_cnt_q <= glitch_cnt_q + 24'h1;
            end
        end else if (vcc_above) begin
            vcc_good_q <= 1'b1;
        end
    end

    // regulator: off in shutdowns and for a restart pause after a vcc failure
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            restart_cnt_q <= 24'h0;
            reg_en_q <= 1'b0;
        end else begin
            if (mode_q == MODE_OFF) begin
                restart_cnt_q <= 24'h0;
            end else if (vcc_fall) begin
                restart_cnt_q <= CNT_W'(RESTART_CYC);
            end else if (restart_cnt_q != 24'h0) begin
                restart_cnt_q <= restart_cnt_q - 24'h1;
            end
            reg_en_q <= (mode_q == MODE_NORMAL || mode_q == MODE_STANDBY)
                        && restart_cnt_q == 24'h0 && !vcc_fall;
        end
    end

    // reset stretch; shutdowns act here only by pulling vcc down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stretch_cnt_q <= 24'h0;
        end else if (!vcc_good_q || wd_fault_q) begin
            stretch_cnt_q <= stretch_len(otp_q.reset_sel);
        end else if (stretch_cnt_q != 24'h0) begin
            stretch_cnt_q <= stretch_cnt_q - 24'h1;
        end
    end

    // open-drain reset pin: low drive only; released while the whole die is off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_oe_n_q <= 1'b1;
        end else begin
            rst_oe_n_q <= !(reset_active && mode_q != MODE_OFF);
        end
    end

    // window watchdog: early or missing trigger both end in a reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wd_phase_q <= WD_IDLE;
            wd_cnt_q <= 24'h0;
            wd_fault_q <= 1'b0;
        end else begin
            wd_fault_q <= 1'b0;
            if (!wd_run || wd_fault_q) begin
                wd_phase_q <= WD_IDLE;
                wd_cnt_q <= 24'h0;
            end else begin
                case (wd_phase_q)
                    WD_IDLE: begin
                        wd_phase_q <= WD_CLOSED;
                        wd_cnt_q <= 24'h0;
                    end
                    WD_CLOSED: begin
                        if (wd_trig_q) begin
                            wd_fault_q <= 1'b1;
                        end else if (wd_cnt_q == closed_len - 24'h1) begin
                            wd_phase_q <= WD_SERVICE;
                            wd_cnt_q <= 24'h0;
                        end else begin
                            wd_cnt_q <= wd_cnt_q + 24'h1;
                        end
                    end
                    WD_SERVICE: begin
                        if (wd_trig_q) begin
                            wd_phase_q <= WD_CLOSED;
                            wd_cnt_q <= 24'h0;
                        end else if (wd_cnt_q == service_len - 24'h1) begin
                            wd_fault_q <= 1'b1;
                        end else begin
                            wd_cnt_q <= wd_cnt_q + 24'h1;
                        end
                    end
                    default: wd_phase_q <= WD_IDLE;
                endcase
            end
        end
    end

    // transmit guard: a stuck dominant tx is cut off until tx goes recessive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_cnt_q <= 24'h0;
            tx_to_q <= 1'b0;
            bus_dom_q <= 1'b0;
        end else begin
            if (mode_q != MODE_NORMAL || tx_in) begin
                tx_cnt_q <= 24'h0;
                tx_to_q <= 1'b0;
            end else if (!tx_to_q) begin
                if (tx_cnt_q == CNT_W'(TXTO_CYC - 1)) begin
                    tx_to_q <= 1'b1;
                end
                tx_cnt_q <= tx_cnt_q + 24'h1;
            end
            bus_dom_q <= (mode_q == MODE_NORMAL) && !tx_in && !tx_to_q;
        end
    end

    // standby wake detection on the low-power receiver
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_cnt_q <= 24'h0;
        end else if (mode_q != MODE_STANDBY || !bus_wake_dominant || wake_hit) begin
            wake_cnt_q <= 24'h0;
        end else begin
            wake_cnt_q <= wake_cnt_q + 24'h1;
        end
    end

    // sticky flags; a hardware set in the clearing cycle wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rwake_q <= 1'b0;
            wd_flag_q <= 1'b0;
            ot_warn_q <= 1'b0;
        end else begin
            if (wake_hit) begin
                rwake_q <= 1'b1;
            end else if (wr_acc && addr_is(paddr, STATUS_OFFS) && pwdata[ST_RWAKE_BIT]) begin
                rwake_q <= 1'b0;
            end
            if (wd_fault_q) begin
                wd_flag_q <= 1'b1;
            end else if (wr_acc && addr_is(paddr, STATUS_OFFS) && pwdata[ST_WD_FAULT_BIT]) begin
                wd_flag_q <= 1'b0;
            end
            if (temp_warn) begin
                ot_warn_q <= 1'b1;
            end else if (temp_rec) begin
                ot_warn_q <= 1'b0;
            end
        end
    end

    // control register; trigger self-clears, shutdown request ends on entry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RST;
            wd_trig_q <= 1'b0;
        end else begin
            wd_trig_q <= wr_acc && addr_is(paddr, CTRL_OFFS) && pwdata[CTRL_WD_TRIG_BIT];
            if (wr_acc && addr_is(paddr, CTRL_OFFS)) begin
                ctrl_q <= pwdata & 32'h0000_000e;
            end else if (mode_q == MODE_TMP_SD || mode_q == MODE_OFF) begin
                ctrl_q[CTRL_TMP_SD_BIT] <= 1'b0;
            end
        end
    end

    // pin-side controls, all registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xcvr_q <= 1'b0;
            atten_q <= 1'b0;
            int_n_q <= 1'b1;
            en_prev_q <= 1'b1;
        end else begin
            en_prev_q <= enable_in;
            xcvr_q <= (mode_q == MODE_NORMAL);
            atten_q <= ctrl_q[CTRL_ATTEN_BIT] && ((mode_q == MODE_NORMAL)
                       || (mode_q == MODE_STANDBY && measurement_enable_input));
            int_n_q <= !rwake_q;
        end
    end

    // apb slave: read data and answer prepared in setup, zero wait states
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !addr_is(paddr, CTRL_OFFS) && !addr_is(paddr, STATUS_OFFS);
            if (setup && addr_is(paddr, CTRL_OFFS)) begin
                prdata_q <= ctrl_q;
            end else if (setup && addr_is(paddr, STATUS_OFFS)) begin
                prdata_q <= {22'h0, wd_flag_q, vcc_good_q, reset_active, tx_to_q,
                             rwake_q, ot_warn_q, 1'b0, mode_q};
            end else if (setup) begin
                prdata_q <= 32'h0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign regulator_en = reg_en_q;
    assign transceiver_en = xcvr_q;
    assign bus_tx_dominant = bus_dom_q;
    assign atten_en = atten_q;
    assign uv_threshold_sel = otp_q.uv_thr_sel;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = rst_oe_n_q;
    assign interrupt_pin_n = int_n_q;
endmodule // supply_reset_watchdog_supervisor
`default_nettype wire

// file: tb/supervisor_properties.sv
// concurrent checks on the supervisor top ports
`default_nettype none
module supervisor_properties
    import supervisor_pkg::*;
#(
    parameter int unsigned TXTO_CYC = 100
) (
    // clock, reset and register bus
    input wire logic clk, rstn, psel, penable, pready, pslverr,
    input wire logic [ADDR_W-1:0] paddr,
    // supply, temperature and bus inputs
    input wire logic battery_supply_good_n, tx_in, temp_shutdown_ind,
    // controls and pins
    input wire logic regulator_en, transceiver_en, bus_tx_dominant,
    input wire logic reset_pin_out, reset_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // run length of dominant drive, saturates well above the timeout
    logic [7:0] dom_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) dom_q <= 8'h00;
        else if (!bus_tx_dominant) dom_q <= 8'h00;
        else if (dom_q != 8'hff) dom_q <= dom_q + 8'h01;
    end
    sequence s_tx_quiet; tx_in [*5]; endsequence
    property p_ready; psel && !penable |=> pready; endproperty
    property p_err; pready && paddr != 12'h000 && paddr != 12'h004 |-> pslverr; endproperty
    property p_pin; !reset_pin_oe_n |-> !reset_pin_out; endproperty
    property p_bat;
        $fell(battery_supply_good_n) |-> ##[1:4] !regulator_en && !transceiver_en;
    endproperty
    property p_regup; $rose(battery_supply_good_n) |-> ##[1:6] regulator_en; endproperty
    property p_therm; $rose(temp_shutdown_ind) |-> ##[1:6] !regulator_en; endproperty
    property p_txrel; s_tx_quiet |-> !bus_tx_dominant; endproperty
    property p_txto; dom_q <= 8'(TXTO_CYC + 4); endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_err: assert property (p_err) else $error("no error on unmapped");
    a_pin: assert property (p_pin) else $error("reset pin not low");
    a_bat: assert property (p_bat) else $error("master reset left block on");
    a_regup: assert property (p_regup) else $error("regulator not started");
    a_therm: assert property (p_therm) else $error("no thermal power down");
    a_txrel: assert property (p_txrel) else $error("dominant without request");
    a_txto: assert property (p_txto) else $error("dominant past timeout");
endmodule // supervisor_properties
`default_nettype wire

// file: tb/reset_line_model.sv
// controller side of the open-drain reset line
`default_nettype none
module reset_line_model (
    // pin drive from the supervisor
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    // level the controller sees
    output logic reset_wire
);
    // pull-up wins whenever the pin is released, so no stale level survives
    assign reset_wire = reset_pin_oe_n ? 1'b1 : reset_pin_out;
endmodule // reset_line_model
`default_nettype wire

// file: tb/supply_reset_watchdog_supervisor_tb.sv
// scenario bench for the supply, reset and watchdog supervisor
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
bind supply_reset_watchdog_supervisor supervisor_properties #(.TXTO_CYC(TXTO_CYC))
    supervisor_properties_inst (.clk, .rstn, .psel, .penable, .pready, .pslverr, .paddr,
    .battery_supply_good_n, .tx_in, .temp_shutdown_ind, .regulator_en, .transceiver_en,
    .bus_tx_dominant, .reset_pin_out, .reset_pin_oe_n);
module supply_reset_watchdog_supervisor_tb import supervisor_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // stimulus, idle or off at time zero except enable_in, which starts high
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic battery_supply_good_n = 0, vcc_below_assert = 1, vcc_above_release = 0;
    logic temp_shutdown_ind = 0, temp_warning_ind = 0, temp_recovery_ind = 0;
    logic enable_in = 1, measurement_enable_input = 0, tx_in = 1, bus_wake_dominant = 0;
    logic reset_pin_in = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    otp_cfg_s otp_cfg = 9'h040; // watchdog off, threshold choice 2
    // design outputs
    logic pready, pslverr, regulator_en, transceiver_en, bus_tx_dominant, atten_en;
    logic reset_pin_out, reset_pin_oe_n, interrupt_pin_n, reset_wire;
    logic [1:0] uv_threshold_sel;
    int miscompares = 0, comparisons = 0, cycles = 0;
    supply_reset_watchdog_supervisor #(.RES_8_CYC(80), .TMP_CYC(200), .TXTO_CYC(100),
        .WAKE_T_CYC(20), .RESTART_CYC(30)) supply_reset_watchdog_supervisor_inst (
        .clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .battery_supply_good_n, .vcc_below_assert, .vcc_above_release, .temp_shutdown_ind,
        .temp_warning_ind, .temp_recovery_ind, .otp_cfg, .enable_in, .measurement_enable_input,
        .tx_in, .bus_wake_dominant, .reset_pin_in, .regulator_en, .transceiver_en,
        .bus_tx_dominant, .atten_en, .uv_threshold_sel, .reset_pin_out, .reset_pin_oe_n,
        .interrupt_pin_n);
    reset_line_model reset_line_model_inst (.reset_pin_out, .reset_pin_oe_n, .reset_wire);
    initial forever #4 clk = ~clk;
    // hang guard: the full sequence needs about 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up;
        end
    end
    task automatic step(input int n); repeat (n) @(posedge clk); endtask
    task automatic vcc(input logic good);
        vcc_below_assert <= !good;
        vcc_above_release <= good;
    endtask
    // one apb transfer, holding the request until ready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_boot;
        battery_supply_good_n <= 1'b1;
        vcc(1'b1);
        step(10);
        `CHK("reg_on", 1'b1, regulator_en)
        `CHK("rst_wire", 1'b0, reset_wire)
        step(50);
        `CHK("rst_hold", 1'b0, reset_pin_oe_n)
        step(40);
        `CHK("rst_free", 1'b1, reset_pin_oe_n)
        `CHK("uv_sel", 2'h2, uv_threshold_sel)
        apb(STATUS_OFFS, 1'b0, 32'h0);
        `CHK("mode", 3'h1, rd[2:0])
        $display("boot done");
    endtask
    task automatic t_regs;
        apb(CTRL_OFFS, 1'b1, 32'h3);
        apb(CTRL_OFFS, 1'b0, 32'h0);
        `CHK("ctrl", 32'h2, rd)
        `CHK("atten", 1'b1, atten_en)
        apb(12'h008, 1'b0, 32'h0);
        `CHK("unmapped", 33'h0_0000_0001, {rd, err})
        $display("regs done");
    endtask
    task automatic t_tx;
        tx_in <= 1'b0;
        step(10);
        `CHK("dom", 1'b1, bus_tx_dominant)
        step(100);
        `CHK("dom_cut", 1'b0, bus_tx_dominant)
        tx_in <= 1'b1;
        $display("tx done");
    endtask
    task automatic t_vcc;
        vcc(1'b0);
        step(1000);
        vcc(1'b1);
        step(40);
        `CHK("glitch", 2'h3, {reset_pin_oe_n, regulator_en})
        vcc(1'b0);
        step(1265);
        `CHK("uv", 2'h0, {reset_pin_oe_n, regulator_en})
        step(135);
        vcc(1'b1);
        step(60);
        `CHK("uv_hold", 1'b0, reset_pin_oe_n)
        step(40);
        `CHK("uv_free", 1'b1, reset_pin_oe_n)
        $display("vcc done");
    endtask
    task automatic t_bat;
        battery_supply_good_n <= 1'b0;
        step(10);
        `CHK("bat_off", 3'h4, {reset_pin_oe_n, regulator_en, transceiver_en})
        battery_supply_good_n <= 1'b1;
        step(10);
        apb(STATUS_OFFS, 1'b0, 32'h0);
        `CHK("bat_mode", 3'h1, rd[2:0])
        step(120);
        $display("bat done");
    endtask
    task automatic t_temp;
        temp_warning_ind <= 1'b1;
        step(5);
        apb(STATUS_OFFS, 1'b0, 32'h0);
        `CHK("warn", 1'b1, rd[4])
        temp_shutdown_ind <= 1'b1;
        step(10);
        `CHK("sd", 2'h2, {reset_pin_oe_n, regulator_en})
        temp_shutdown_ind <= 1'b0;
        temp_warning_ind <= 1'b0;
        temp_recovery_ind <= 1'b1;
        step(10);
        apb(STATUS_OFFS, 1'b0, 32'h0);
        `CHK("recover", 2'h2, {regulator_en, rd[4]})
        temp_recovery_ind <= 1'b0;
        $display("temp done");
    endtask
    task automatic t_stby;
        enable_in <= 1'b0;
        step(10);
        `CHK("atten_sb", 1'b0, atten_en)
        measurement_enable_input <= 1'b1;
        step(5);
        `CHK("atten_men", 1'b1, atten_en)
        bus_wake_dominant <= 1'b1;
        step(30);
        `CHK("wake_int", 1'b0, interrupt_pin_n)
        apb(STATUS_OFFS, 1'b0, 32'h0);
        `CHK("wake", 4'h9, {rd[5], rd[2:0]})
        $display("standby done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        step(10);
        rstn <= 1'b1;
        t_boot;
        t_regs;
        t_tx;
        t_vcc;
        t_bat;
        t_temp;
        t_stby;
        wrap_up;
    end
endmodule // supply_reset_watchdog_supervisor_tb
`default_nettype wire
